// ===== verilog/fpqs_target.sv
// response queue towards the frame transmitter
module fpqs_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = fpqs_pkg::FIFO_DEPTH
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
   logic             full, empty;

   // pointer bookkeeping
   always_comb begin
      full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
      empty     = (wp_q == rp_q);
      in_ready  = !full;
      out_valid = !empty;
      out_data  = mem_q[rp_q[AW-1:0]];
      wp_d      = wp_q + (AW+1)'(in_valid && !full);
      rp_d      = rp_q + (AW+1)'(out_ready && !empty);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
      if (in_valid && !full) begin
         mem_q[wp_q[AW-1:0]] <= in_data;
      end
   end
endmodule : fpqs_fifo

// boot loader answer sequencer for version, checksum and security commands
module fpqs_target #(
   parameter int                      VER_LEN = fpqs_pkg::VER_BYTES,
   parameter logic [VER_LEN*8-1:0]    VERSION = '0  // arbitrary value
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  cmd_valid,
   output logic                       cmd_ready,
   input  wire fpqs_pkg::fpqs_cmd_t   cmd,
   input  wire logic                  dat_valid,
   output logic                       dat_ready,
   input  wire fpqs_pkg::fpqs_dat_t   dat,
   output logic                       sum_req,
   output logic [23:0]                sum_start,
   output logic [23:0]                sum_end,
   input  wire logic                  sum_done,
   input  wire logic [15:0]           sum_value,
   input  wire logic                  erase_write_error,
   input  wire logic                  security_prohibited,
   output logic                       sec_wr_req,
   output logic [7:0]                 sec_flag,
   input  wire logic                  sec_wr_done,
   input  wire logic                  sec_wr_fail,
   input  wire logic                  internal_verify_error,
   output logic                       busy,
   output logic                       tx_valid,
   input  wire logic                  tx_ready,
   output fpqs_pkg::fpqs_tx_t         tx
);
   fpqs_pkg::fpqs_state_t state_q, state_d;
   fpqs_pkg::fpqs_tx_t    pword;
   logic [5:0][7:0]       prm_q, prm_d;
   logic [15:0]           sum_q, sum_d;
   logic [3:0]            idx_q, idx_d, len_q, len_d;
   logic                  mode_sum_q, mode_sum_d;
   logic                  wfail_q, wfail_d, vfail_q, vfail_d;
   logic                  sreq_d, wreq_d, push, fifo_rdy;
   logic [7:0]            flag_q, flag_d;
   logic                  acc_cmd, acc_dat, idle, nack_busy, misalign;

   // byte of an outgoing data frame, high byte first
   function automatic logic [7:0] data_byte(input logic sm,
                                            input logic [3:0] i,
                                            input logic [15:0] s);
      if (sm) begin
         data_byte = (i == 4'h0) ? s[15:8] : s[7:0];
      end else begin
         data_byte = VERSION[(VER_LEN-1-int'(i))*8 +: 8];
      end
   endfunction : data_byte

   function automatic fpqs_pkg::fpqs_tx_t status(input logic [7:0] b);
      status = '{is_status: 1'b1, last: 1'b1, data: b};
   endfunction : status

   // handshakes towards the frame receiver stall on a full queue
   always_comb begin
      idle      = (state_q == fpqs_pkg::S_IDLE);
      cmd_ready = fifo_rdy;
      acc_cmd   = cmd_valid && fifo_rdy;
      nack_busy = acc_cmd && !idle && (cmd.code != fpqs_pkg::CMD_STATUS);
      dat_ready = fifo_rdy && !nack_busy &&
                  (state_q == fpqs_pkg::S_SECDAT);
      acc_dat   = dat_valid && dat_ready;
      misalign  = (cmd.prm[5:3] & 24'((1 << fpqs_pkg::BLK_BITS) - 1)) != '0
               || (~cmd.prm[2:0] & 24'((1 << fpqs_pkg::BLK_BITS) - 1))
                  != '0;
   end

   // command sequencing
   always_comb begin
      state_d = state_q;  prm_d = prm_q;  sum_d = sum_q;
      idx_d = idx_q;  len_d = len_q;  mode_sum_d = mode_sum_q;
      wfail_d = wfail_q;  vfail_d = vfail_q;  flag_d = flag_q;
      sreq_d = 1'b0;  wreq_d = 1'b0;  push = 1'b0;  pword = '0;
      if (nack_busy) begin
         // R7 busy reject
         push  = 1'b1;
         pword = status(fpqs_pkg::ST_NACK);
      end else begin
         case (state_q)
            fpqs_pkg::S_IDLE: begin
               if (acc_cmd && cmd.code != fpqs_pkg::CMD_STATUS) begin
                  push = 1'b1;
                  if (!cmd.len_ok || !cmd.etx_ok) begin
                     // R7 malformed frame
                     pword = status(fpqs_pkg::ST_NACK);
                  end else if (!cmd.csum_ok) begin
                     // R6 command checksum
                     pword = status(fpqs_pkg::ST_CSUM);
                  end else begin
                     case (cmd.code)
                        fpqs_pkg::CMD_VERSION: begin
                           // R2 acknowledge first
                           pword = status(fpqs_pkg::ST_ACK);
                           idx_d = '0;
                           len_d = 4'(VER_LEN);
                           mode_sum_d = 1'b0;
                           state_d = fpqs_pkg::S_EMIT;
                        end
                        fpqs_pkg::CMD_CHECKSUM: begin
                           // R9 block alignment
                           if (misalign) begin
                              pword = status(fpqs_pkg::ST_PARAM);
                           end else begin
                              pword = status(fpqs_pkg::ST_ACK);
                              prm_d = cmd.prm;
                              sreq_d = 1'b1;
                              state_d = fpqs_pkg::S_SUMW;
                           end
                        end
                        fpqs_pkg::CMD_SECURITY: begin
                           if (cmd.prm[5] != fpqs_pkg::ZERO_BYTE ||
                               cmd.prm[4] != fpqs_pkg::ZERO_BYTE) begin
                              // R12 block and page zero
                              pword = status(fpqs_pkg::ST_PARAM);
                           end else if (erase_write_error) begin
                              // R17 write failure
                              pword = status(fpqs_pkg::ST_ERWR);
                           end else begin
                              pword = status(fpqs_pkg::ST_ACK);
                              state_d = fpqs_pkg::S_SECDAT;
                           end
                        end
                        default: pword = status(fpqs_pkg::ST_CMD_ERR);
                     endcase
                  end
               end
            end
            fpqs_pkg::S_SUMW: begin
               if (sum_done) begin
                  sum_d = sum_value;
                  idx_d = '0;
                  len_d = 4'(fpqs_pkg::SUM_BYTES);
                  mode_sum_d = 1'b1;
                  state_d = fpqs_pkg::S_EMIT;
               end
            end
            fpqs_pkg::S_EMIT: begin
               if (fifo_rdy) begin
                  push  = 1'b1;
                  pword = '{is_status: 1'b0, last: (idx_q == len_q - 4'h1),
                            data: data_byte(mode_sum_q, idx_q, sum_q)};
                  idx_d = idx_q + 4'h1;
                  if (idx_q == len_q - 4'h1) begin
                     state_d = fpqs_pkg::S_IDLE;
                  end
               end
            end
            fpqs_pkg::S_SECDAT: begin
               if (acc_dat) begin
                  push = 1'b1;
                  state_d = fpqs_pkg::S_IDLE;
                  if (!dat.csum_ok) begin
                     // R6 data checksum
                     pword = status(fpqs_pkg::ST_CSUM);
                  end else if (security_prohibited) begin
                     // R15 prohibited setting
                     pword = status(fpqs_pkg::ST_PROTECT);
                  end else begin
                     push = 1'b0;
                     flag_d = dat.security_flag_byte;
                     wreq_d = 1'b1;
                     state_d = fpqs_pkg::S_SECWR;
                  end
               end
            end
            fpqs_pkg::S_SECWR: begin
               if (sec_wr_done) begin
                  wfail_d = sec_wr_fail;
                  vfail_d = internal_verify_error;
                  state_d = fpqs_pkg::S_SECRP;
               end
            end
            fpqs_pkg::S_SECRP: begin
               if (fifo_rdy) begin
                  // R15 write result
                  push  = 1'b1;
                  pword = status(wfail_q ? fpqs_pkg::ST_WRITE
                                         : fpqs_pkg::ST_ACK);
                  state_d = wfail_q ? fpqs_pkg::S_IDLE : fpqs_pkg::S_SECVF;
               end
            end
            fpqs_pkg::S_SECVF: begin
               if (fifo_rdy) begin
                  // R16 verify status
                  push  = 1'b1;
                  pword = status(vfail_q ? fpqs_pkg::ST_VERIFY
                                         : fpqs_pkg::ST_ACK);
                  state_d = fpqs_pkg::S_IDLE;
               end
            end
            default: state_d = fpqs_pkg::S_IDLE;
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= fpqs_pkg::S_IDLE;  prm_q <= '0;  sum_q <= '0;
         idx_q <= '0;  len_q <= '0;  mode_sum_q <= 1'b0;
         wfail_q <= 1'b0;  vfail_q <= 1'b0;  flag_q <= '0;
         sum_req <= 1'b0;  sec_wr_req <= 1'b0;
      end else begin
         state_q <= state_d;  prm_q <= prm_d;  sum_q <= sum_d;
         idx_q <= idx_d;  len_q <= len_d;  mode_sum_q <= mode_sum_d;
         wfail_q <= wfail_d;  vfail_q <= vfail_d;  flag_q <= flag_d;
         sum_req <= sreq_d;  sec_wr_req <= wreq_d;
      end
   end

   assign sum_start = prm_q[5:3];
   assign sum_end   = prm_q[2:0];
   assign sec_flag  = flag_q;
   assign busy      = !idle;

   fpqs_fifo #(
      .WIDTH ($bits(fpqs_pkg::fpqs_tx_t)),
      .DEPTH (fpqs_pkg::FIFO_DEPTH)
   ) u_txq (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_rdy),
      .in_data   (pword),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_CMD_CSUM: assert property ( // R6
      idle && acc_cmd && cmd.len_ok && cmd.etx_ok && !cmd.csum_ok &&
      cmd.code != fpqs_pkg::CMD_STATUS
      |-> push && pword.data == fpqs_pkg::ST_CSUM ##1 idle)
      else $error("bad command checksum not answered 07H");
   AST_DAT_CSUM: assert property ( // R6
      acc_dat && !nack_busy && !dat.csum_ok
      |-> pword.data == fpqs_pkg::ST_CSUM ##1 idle)
      else $error("bad data checksum not answered 07H");
   AST_MALFORMED: assert property ( // R7
      idle && acc_cmd && !cmd.len_ok && cmd.code != fpqs_pkg::CMD_STATUS
      |-> push && pword.data == fpqs_pkg::ST_NACK)
      else $error("malformed frame not answered 15H");
   AST_BUSY_NACK: assert property ( // R7
      nack_busy |-> push && pword.data == fpqs_pkg::ST_NACK
      ##1 state_q == $past(state_q))
      else $error("busy command not rejected with 15H");
   AST_ALIGN: assert property ( // R9
      idle && acc_cmd && cmd.len_ok && cmd.etx_ok && cmd.csum_ok &&
      cmd.code == fpqs_pkg::CMD_CHECKSUM && misalign
      |-> pword.data == fpqs_pkg::ST_PARAM ##1 idle && !sum_req)
      else $error("misaligned range not answered 05H");
   AST_SEC_PARAM: assert property ( // R12
      idle && push && pword.data == fpqs_pkg::ST_ACK &&
      cmd.code == fpqs_pkg::CMD_SECURITY
      |-> cmd.prm[5] == fpqs_pkg::ZERO_BYTE &&
          cmd.prm[4] == fpqs_pkg::ZERO_BYTE && !erase_write_error)
      else $error("security acknowledged with nonzero block or page");
   AST_ERWR: assert property ( // R17
      ##1 state_q == fpqs_pkg::S_SECDAT && $past(idle)
      |-> !$past(erase_write_error))
      else $error("security command accepted despite write failure");
   AST_PROT: assert property ( // R15
      acc_dat && !nack_busy && dat.csum_ok && security_prohibited
      |-> pword.data == fpqs_pkg::ST_PROTECT ##1 idle && !sec_wr_req)
      else $error("prohibited setting not answered 10H");
   AST_WRFAIL: assert property ( // R15
      state_q == fpqs_pkg::S_SECWR && sec_wr_done && sec_wr_fail
      ##1 fifo_rdy && !nack_busy
      |-> pword.data == fpqs_pkg::ST_WRITE ##1 idle)
      else $error("write failure not answered 1CH");
   AST_VERIFY: assert property ( // R16
      state_q == fpqs_pkg::S_SECVF && push && !nack_busy
      |-> pword.data == (vfail_q ? fpqs_pkg::ST_VERIFY : fpqs_pkg::ST_ACK))
      else $error("verify status wrong");
   AST_VER_ACK: assert property ( // R2
      idle && acc_cmd && cmd.len_ok && cmd.etx_ok && cmd.csum_ok &&
      cmd.code == fpqs_pkg::CMD_VERSION
      |-> pword.data == fpqs_pkg::ST_ACK ##1 state_q == fpqs_pkg::S_EMIT)
      else $error("version command not acknowledged");

   COV_VERSION: cover property (state_q == fpqs_pkg::S_EMIT && !mode_sum_q
      && push && pword.last);
   COV_SUM: cover property (state_q == fpqs_pkg::S_EMIT && mode_sum_q
      && push && pword.last);
   COV_SEC_OK: cover property (state_q == fpqs_pkg::S_SECVF && push
      && pword.data == fpqs_pkg::ST_ACK);
   COV_BUSY: cover property (nack_busy);
endmodule : fpqs_target

// ===== verilog/fpqs_pkg.sv
// Contract
// R1: host waits the command gap after the last received frame before sending.
// R2: status byte 06H means acknowledge; any other value fails the step.
// R3: host times version command status against the version status timeout.
// R4: after version acknowledge host awaits data within short data timeout.
// R5: host reports data frame error when received data frame checksum mismatches.
// R6: target answers 07H on a bad command or data frame checksum.
// R7: target answers 15H on malformed frame or non-status command while busy.
// R8: host times checksum status, then long data frame timeout for data.
// R9: target answers 05H when checksum range is not 1 KB block aligned.
// R10: checksum command carries code plus start and end, high byte first.
// R11: host builds 16-bit checksum from first two data bytes, first high.
// R12: security block and page bytes must be 00H, else target answers 05H.
// R13: host waits data frame gap after security acknowledge before data frame.
// R14: security data is one final two-byte frame: flag OR E8H, then 03H.
// R15: target answers 10H for prohibited setting, 1CH on write failure.
// R16: second status after security data; 1BH on internal verify failure.
// R17: target answers 1AH to the security command on write failure.
// R18: host ends with timeout class when an expected frame never arrives.
// R19: host reports distinct classes A to E and stops at the first end.
package fpqs_pkg;
   localparam logic [7:0] ST_CMD_ERR = 8'h04;
   localparam logic [7:0] ST_PARAM   = 8'h05;
   localparam logic [7:0] ST_ACK     = 8'h06;
   localparam logic [7:0] ST_CSUM    = 8'h07;
   localparam logic [7:0] ST_PROTECT = 8'h10;
   localparam logic [7:0] ST_NACK    = 8'h15;
   localparam logic [7:0] ST_ERWR    = 8'h1A;
   localparam logic [7:0] ST_VERIFY  = 8'h1B;
   localparam logic [7:0] ST_WRITE   = 8'h1C;
   // command codes
   localparam logic [7:0] CMD_STATUS   = 8'h70;
   localparam logic [7:0] CMD_VERSION  = 8'hC5;
   localparam logic [7:0] CMD_CHECKSUM = 8'hB0;
   localparam logic [7:0] CMD_SECURITY = 8'hA0;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;
   localparam int         BLK_BITS     = 10;   // 1 KB block
   localparam int         SUM_BYTES    = 2;
   localparam int         FIFO_DEPTH   = 8;
   localparam int         VER_BYTES    = 6;

   typedef struct packed {
      logic [7:0]      code;
      logic            len_ok;     // length_field consistent
      logic            etx_ok;     // end_of_text_marker present
      logic            csum_ok;
      logic [5:0][7:0] prm;        // prm[5] first byte received
   } fpqs_cmd_t;

   typedef struct packed {
      logic [7:0] security_flag_byte;
      logic [7:0] boot_field_byte;
      logic       csum_ok;
   } fpqs_dat_t;

   typedef struct packed {
      logic       is_status;
      logic       last;
      logic [7:0] data;
   } fpqs_tx_t;

   typedef enum logic [6:0] {
      S_IDLE   = 7'b0000001,
      S_EMIT   = 7'b0000010,
      S_SUMW   = 7'b0000100,
      S_SECDAT = 7'b0001000,
      S_SECWR  = 7'b0010000,
      S_SECRP  = 7'b0100000,
      S_SECVF  = 7'b1000000
   } fpqs_state_t;
endpackage : fpqs_pkg

// ===== sim/fpqs_host_model.sv
// programmer side of the boot link: sends frames, collects answers
module fpqs_host_model #(
   parameter int CMD_GAP = 4,
   parameter int DAT_GAP = 3
) (
   input  wire logic               mclk,
   output logic                    cmd_valid,
   input  wire logic               cmd_ready,
   output fpqs_pkg::fpqs_cmd_t     cmd,
   output logic                    dat_valid,
   input  wire logic               dat_ready,
   output fpqs_pkg::fpqs_dat_t     dat,
   input  wire logic               tx_valid,
   output logic                    tx_ready,
   input  wire fpqs_pkg::fpqs_tx_t tx,
   input  wire logic               stall
);
   timeunit 1ns;
   timeprecision 100ps;
   fpqs_pkg::fpqs_tx_t rx[$];

   // idle drive values
   initial begin
      cmd_valid = 1'b0;
      dat_valid = 1'b0;
      cmd       = '0;
      dat       = '0;
   end

   task automatic send_cmd(input fpqs_pkg::fpqs_cmd_t c);
      repeat (CMD_GAP) @(posedge mclk);
      cmd       <= c;
      cmd_valid <= 1'b1;
      do @(negedge mclk); while (cmd_ready !== 1'b1);
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd       <= ~c;   // released lines show garbage
   endtask : send_cmd

   task automatic send_dat(input logic [7:0] flag, input logic ok);
      repeat (DAT_GAP) @(posedge mclk);
      dat       <= '{flag | 8'hE8, 8'h03, ok};
      dat_valid <= 1'b1;
      do @(negedge mclk); while (dat_ready !== 1'b1);
      @(posedge mclk);
      dat_valid <= 1'b0;
      dat       <= ~dat;
   endtask : send_dat

   // answer sink, may stall
   assign tx_ready = ~stall;
   always @(posedge mclk) begin
      if (tx_valid && tx_ready) rx.push_back(tx);
   end
endmodule : fpqs_host_model

// ===== sim/tb_top.sv
// answer sequencer bench
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [47:0] VER = 48'h0123456789AB; // arbitrary value
   logic                mclk, rst, stall, cmd_valid, cmd_ready;
   logic                dat_valid, dat_ready, sum_req, sum_done;
   logic                erase_write_error, security_prohibited;
   logic                sec_wr_req, sec_wr_done, sec_wr_fail;
   logic                internal_verify_error, busy, tx_valid, tx_ready;
   logic [23:0]         sum_start, sum_end;
   logic [15:0]         sum_value;
   logic [7:0]          sec_flag;
   fpqs_pkg::fpqs_cmd_t cmd;
   fpqs_pkg::fpqs_dat_t dat;
   fpqs_pkg::fpqs_tx_t  tx;
   logic [9:0]          exq[$];
   int                  num_errors = 0;
   int                  checks = 0;
   logic [2:0]          fl[4] = '{3'b011, 3'b101, 3'b110, 3'b010};
   logic [7:0]          fe[4] = '{8'h15, 8'h15, 8'h07, 8'h15};

   fpqs_target #(.VER_LEN(6), .VERSION(VER)) dut (.*);
   fpqs_host_model host (.*);

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic chk(input logic [47:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   function automatic fpqs_pkg::fpqs_cmd_t mk(input logic [7:0] c,
                                             input logic [47:0] p,
                                             input logic [2:0] f);
      return '{c, f[2], f[1], f[0], p};
   endfunction : mk

   task automatic st(input logic [7:0] b);
      exq.push_back({2'b11, b});
   endtask : st

   task automatic ver_exp();
      st(fpqs_pkg::ST_ACK);
      for (int i = 5; i >= 0; i--) exq.push_back({1'b0, i == 0, VER[i*8+:8]});
   endtask : ver_exp

   // wait for all expected words, then compare in order
   task automatic drain(input string name);
      int n;
      n = 0;
      while (host.rx.size() < exq.size() && n < 300) begin
         @(posedge mclk);
         n++;
      end
      repeat (4) @(posedge mclk);
      chk(host.rx.size(), exq.size(), "word count");
      while (exq.size() > 0 && host.rx.size() > 0)
         chk(host.rx.pop_front(), exq.pop_front(), "answer word");
      exq.delete();
      host.rx.delete();
      $display("test %s done", name);
   endtask : drain

   task automatic wait_hi(ref logic s, input string what);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      chk(s, 1, what);
   endtask : wait_hi

   task automatic wr_pulse(input logic fail, input logic verr);
      @(posedge mclk);
      sec_wr_done           <= 1'b1;
      sec_wr_fail           <= fail;
      internal_verify_error <= verr;
      @(posedge mclk);
      sec_wr_done           <= 1'b0;
   endtask : wr_pulse

   task automatic summarize();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      summarize();
   end

   // test sequence
   initial begin
      rst = 1'b1; stall = 1'b0; sum_done = 1'b0; sum_value = '0;
      erase_write_error = 1'b0; security_prohibited = 1'b0;
      sec_wr_done = 1'b0; sec_wr_fail = 1'b0; internal_verify_error = 1'b0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk(cmd_ready, 1, "ready after reset");
      chk({busy, tx_valid}, 0, "idle after reset");
      host.send_cmd(mk(fpqs_pkg::CMD_VERSION, '0, 3'b111));
      ver_exp();
      drain("version");
      // frame faults on a version command
      // no data after reject
      for (int k = 0; k < 4; k++) begin
         host.send_cmd(mk(fpqs_pkg::CMD_VERSION, '0, fl[k]));
         st(fe[k]);
      end
      // unknown command code
      host.send_cmd(mk(8'h3C, '0, 3'b111));
      st(fpqs_pkg::ST_CMD_ERR);
      drain("frame faults");
      host.send_cmd(mk(fpqs_pkg::CMD_CHECKSUM, 48'h0004000007FF, 3'b111));
      wait_hi(sum_req, "sum request");
      chk({sum_start, sum_end}, 48'h0004000007FF, "range");
      chk(busy, 1, "busy in checksum");
      host.send_cmd(mk(fpqs_pkg::CMD_VERSION, '0, 3'b111));
      host.send_cmd(mk(fpqs_pkg::CMD_STATUS, '0, 3'b111));
      sum_value <= 16'hBEEF;
      @(posedge mclk);
      sum_done <= 1'b1;
      @(posedge mclk);
      sum_done <= 1'b0;
      st(fpqs_pkg::ST_ACK);
      st(fpqs_pkg::ST_NACK);
      exq.push_back(10'h0BE);
      exq.push_back(10'h1EF);
      drain("checksum busy");
      host.send_cmd(mk(fpqs_pkg::CMD_CHECKSUM, 48'h0004010007FF, 3'b111));
      host.send_cmd(mk(fpqs_pkg::CMD_CHECKSUM, 48'h0004000007FE, 3'b111));
      st(fpqs_pkg::ST_PARAM);
      st(fpqs_pkg::ST_PARAM);
      host.send_cmd(mk(fpqs_pkg::CMD_SECURITY, 48'h01 << 40, 3'b111));
      host.send_cmd(mk(fpqs_pkg::CMD_SECURITY, 48'h01 << 32, 3'b111));
      st(fpqs_pkg::ST_PARAM);
      st(fpqs_pkg::ST_PARAM);
      erase_write_error <= 1'b1;
      host.send_cmd(mk(fpqs_pkg::CMD_SECURITY, '0, 3'b111));
      erase_write_error <= 1'b0;
      st(fpqs_pkg::ST_ERWR);
      drain("parameter faults");
      // data stage: bad sum, prohibited, write fail, verify fail, good
      for (int k = 0; k < 5; k++) begin
         security_prohibited <= (k == 1);
         host.send_cmd(mk(fpqs_pkg::CMD_SECURITY, '0, 3'b111));
         host.send_dat(8'(k), k != 0);
         st(fpqs_pkg::ST_ACK);
         if (k == 0) st(fpqs_pkg::ST_CSUM);
         if (k == 1) st(fpqs_pkg::ST_PROTECT);
         if (k > 1) begin
            wait_hi(sec_wr_req, "write request");
            chk(sec_flag, 8'(k) | 8'hE8, "flag byte");
            wr_pulse(k == 2, k == 3);
            st(k == 2 ? fpqs_pkg::ST_WRITE : fpqs_pkg::ST_ACK);
            if (k > 2) st(k == 3 ? fpqs_pkg::ST_VERIFY : fpqs_pkg::ST_ACK);
         end
         drain("security");
      end
      // fill the answer queue with the far side stalled
      stall <= 1'b1;
      host.send_cmd(mk(fpqs_pkg::CMD_VERSION, '0, 3'b111));
      // let the version frame finish, else the range is a busy reject
      do @(negedge mclk); while (busy);
      host.send_cmd(mk(fpqs_pkg::CMD_CHECKSUM, 48'h0004010007FF, 3'b111));
      ver_exp();
      st(fpqs_pkg::ST_PARAM);
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      chk(cmd_ready, 0, "queue full");
      @(posedge mclk);
      stall <= 1'b0;
      drain("queue fill");
      summarize();
   end
endmodule : tb_top
